// [verilog/rx_frame_cfg.svh]
`ifndef RX_FRAME_CFG_SVH
`define RX_FRAME_CFG_SVH

// ==========================================
// frame type codes
`define RXF_TYPE_DATA64 8'h80
`define RXF_TYPE_DATA16 8'h81
`define RXF_TYPE_IO64 8'h82
`define RXF_TYPE_IO16 8'h83

// ==========================================
// frame layout
`define RXF_OFF_TYPE 8'h04
`define RXF_ADDR16_LAST 3'h1
`define RXF_ADDR64_LAST 3'h7
`define RXF_PAYLOAD_MAX 7'h64
`define RXF_OPT_ADDR_BCAST 1
`define RXF_OPT_PAN_BCAST 2

// ==========================================
// register map, byte addresses
`define RXF_REG_CTRL 8'h00
`define RXF_REG_STATUS 8'h04
`define RXF_CTRL_ENABLE 0
`define RXF_CTRL_CLEAR 1
`define RXF_CTRL_RESET 1'b1
`define RXF_STAT_BUSY 0
`define RXF_STAT_TRUNC_LSB 8
`define RXF_STAT_FRAMES_LSB 16

`endif

// [verilog/rx_frame_pkg.sv]
package rx_frame_pkg;

   // ==========================================
   // packet descriptor handed over by the radio side
   typedef struct packed {
      logic is_io;
      logic addr64;
      logic [63:0] src_addr;
      logic [7:0] strength;
      logic addr_bcast;
      logic pan_bcast;
      logic [3:0] analog_channel_select_bits;
      logic [8:0] digital_line_select_bits;
   } pkt_desc_t;

   // payload byte with its end marker
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } pay_word_t;

   typedef enum logic [3:0] {
      S_IDLE,
      S_TYPE,
      S_ADDR,
      S_STRENGTH,
      S_OPTS,
      S_CHAN_HI,
      S_CHAN_LO,
      S_DATA,
      S_DISCARD
   } build_state_t;

   typedef struct packed {
      build_state_t state;
      pkt_desc_t desc;
      logic [2:0] idx;
      logic [6:0] pay_cnt;
      logic pkt_ready;
      logic out_valid;
      logic [7:0] out_data;
      logic out_last;
      logic [7:0] out_offset;
      logic enable;
      logic [15:0] frames;
      logic [7:0] truncs;
      logic ack;
      logic waitreq;
      logic [31:0] rdata;
   } builder_st_t;

endpackage

// [verilog/pay_fifo.sv]
`timescale 1ns/1ps

// small first-in first-out buffer; ready on the filling side is a flop
module pay_fifo
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
)
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [CW-1:0] cnt;
      logic room;
   } fifo_st_t;

   fifo_st_t s;
   fifo_st_t next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // ==========================================
   // handshakes
   assign push = in_valid_i & s.room;
   assign pop = out_valid_o & out_ready_i;
   assign in_ready_o = s.room; // straight from a flop, no inverter
   assign out_valid_o = (s.cnt != '0);
   assign out_data_o = mem[s.rd];

   // pointers wrap explicitly so depths other than powers of two work
   always_comb
   begin
      next_s = s;
      if (push)
      begin
         next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
      end
      if (pop)
      begin
         next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
      end
      if (push & ~pop)
      begin
         next_s.cnt = s.cnt + 1'b1;
      end
      else if (pop & ~push)
      begin
         next_s.cnt = s.cnt - 1'b1;
      end
      next_s.room = (next_s.cnt != CW'(DEPTH));
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s <= '0;
         s.room <= 1'b1; // an empty buffer has room
      end
      else
      begin
         s <= next_s;
      end
   end

   // storage carries no reset, it is only read behind a valid count
   always_ff @(posedge core_clk_i)
   begin
      if (push)
      begin
         mem[s.wr] <= in_data_i;
      end
   end

endmodule

// [verilog/rx_api_frame_builder.sv]
`timescale 1ns/1ps
`include "rx_frame_cfg.svh"

module rx_api_frame_builder
#(
   parameter int FIFO_DEPTH = 8
)
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // packet descriptor from the radio side
   input wire logic pkt_valid_i,
   input wire rx_frame_pkg::pkt_desc_t pkt_desc_i,
   output logic pkt_ready_o,
   // payload bytes from the radio side
   input wire logic pay_valid_i,
   input wire logic [7:0] pay_data_i,
   input wire logic pay_last_i,
   output logic pay_ready_o,
   // frame bytes towards the uart, starting at the type byte
   output logic out_valid_o,
   output logic [7:0] out_data_o,
   output logic out_last_o,
   output logic [7:0] out_offset_o,
   input wire logic out_ready_i,
   // avalon-mm slave
   input wire logic [7:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o
);

   // the offset counter is eight bits; the longest frame ends at 114
   rx_frame_pkg::builder_st_t s;
   rx_frame_pkg::builder_st_t next_s;
   rx_frame_pkg::pay_word_t fifo_in;
   rx_frame_pkg::pay_word_t fifo_out;
   logic fifo_valid;
   logic fifo_pop;
   logic can_load;
   logic [15:0] chan_ind;

   // ==========================================
   // payload buffer
   // one driver for the whole word keeps the end marker beside its byte
   assign fifo_in = {pay_last_i, pay_data_i};

   pay_fifo
   #(
      .WIDTH($bits(rx_frame_pkg::pay_word_t)),
      .DEPTH(FIFO_DEPTH)
   )
   u_pay_fifo
   (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(pay_valid_i),
      .in_data_i(fifo_in),
      .in_ready_o(pay_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_out),
      .out_ready_i(fifo_pop)
   );

   // ==========================================
   // output stage and fifo drain
   // the output byte register is free when empty or being taken this cycle
   assign can_load = ~s.out_valid | out_ready_i;
   // discarding drains without waiting on the uart side
   assign fifo_pop = fifo_valid &
      (((s.state == rx_frame_pkg::S_DATA) & can_load) |
       (s.state == rx_frame_pkg::S_DISCARD));
   // channel indicator goes out high byte first, reserved bits as zero
   assign chan_ind = {3'b000, s.desc.analog_channel_select_bits,
      s.desc.digital_line_select_bits};

   // every output is a field of the state register, pay_ready_o a flop of the
   // payload buffer, so no logic sits between a flop and a pin
   assign pkt_ready_o = s.pkt_ready;
   assign out_valid_o = s.out_valid;
   assign out_data_o = s.out_data;
   assign out_last_o = s.out_last;
   assign out_offset_o = s.out_offset;
   assign readdata_o = s.rdata;
   assign waitrequest_o = s.waitreq;

   // ==========================================
   // next state of the whole block
   always_comb
   begin
      next_s = s;
      if (s.out_valid & out_ready_i)
      begin
         next_s.out_valid = 1'b0;
      end
      // one frame byte is loaded per cycle while the output stage is free;
      // type, address, strength and options come from the held
      // descriptor, then the channel indicator for sample frames, then
      // the buffered payload
      case (s.state)
         rx_frame_pkg::S_IDLE:
         begin
            // the descriptor is copied so the radio side may move on
            if (pkt_valid_i & s.pkt_ready)
            begin
               next_s.desc = pkt_desc_i;
               next_s.state = rx_frame_pkg::S_TYPE;
            end
         end
         rx_frame_pkg::S_TYPE:
         begin
            if (can_load)
            begin
               next_s.out_valid = 1'b1;
               next_s.out_last = 1'b0;
               next_s.out_offset = `RXF_OFF_TYPE;
               if (s.desc.is_io)
               begin
                  next_s.out_data = s.desc.addr64 ? `RXF_TYPE_IO64
                     : `RXF_TYPE_IO16;
               end
               else
               begin
                  next_s.out_data = s.desc.addr64 ? `RXF_TYPE_DATA64
                     : `RXF_TYPE_DATA16;
               end
               // address width decides the field positions after it
               next_s.idx = s.desc.addr64 ? `RXF_ADDR64_LAST
                  : `RXF_ADDR16_LAST;
               next_s.state = rx_frame_pkg::S_ADDR;
            end
         end
         rx_frame_pkg::S_ADDR:
         begin
            if (can_load)
            begin
               next_s.out_valid = 1'b1;
               next_s.out_offset = s.out_offset + 8'h01;
               next_s.out_data = s.desc.src_addr[{s.idx, 3'b000} +: 8];
               // idx counts the address bytes down, most significant first
               next_s.idx = s.idx - 3'h1;
               if (s.idx == 3'h0)
               begin
                  next_s.state = rx_frame_pkg::S_STRENGTH;
               end
            end
         end
         rx_frame_pkg::S_STRENGTH:
         begin
            if (can_load)
            begin
               next_s.out_valid = 1'b1;
               next_s.out_offset = s.out_offset + 8'h01;
               next_s.out_data = s.desc.strength;
               next_s.state = rx_frame_pkg::S_OPTS;
            end
         end
         rx_frame_pkg::S_OPTS:
         begin
            if (can_load)
            begin
               next_s.out_valid = 1'b1;
               next_s.out_offset = s.out_offset + 8'h01;
               // reserved positions are always sent as zero
               next_s.out_data = 8'h00;
               next_s.out_data[`RXF_OPT_ADDR_BCAST] = s.desc.addr_bcast;
               next_s.out_data[`RXF_OPT_PAN_BCAST] = s.desc.pan_bcast;
               // channel bytes of sample frames count towards the limit
               next_s.pay_cnt = 7'h00;
               next_s.state = s.desc.is_io ? rx_frame_pkg::S_CHAN_HI
                  : rx_frame_pkg::S_DATA;
            end
         end
         rx_frame_pkg::S_CHAN_HI:
         begin
            if (can_load)
            begin
               next_s.out_valid = 1'b1;
               next_s.out_offset = s.out_offset + 8'h01;
               next_s.out_data = chan_ind[15:8];
               next_s.pay_cnt = s.pay_cnt + 7'h01;
               next_s.state = rx_frame_pkg::S_CHAN_LO;
            end
         end
         rx_frame_pkg::S_CHAN_LO:
         begin
            if (can_load)
            begin
               next_s.out_valid = 1'b1;
               next_s.out_offset = s.out_offset + 8'h01;
               next_s.out_data = chan_ind[7:0];
               next_s.pay_cnt = s.pay_cnt + 7'h01;
               next_s.state = rx_frame_pkg::S_DATA;
            end
         end
         rx_frame_pkg::S_DATA:
         begin
            // a byte leaves the buffer only when the output stage is free
            if (fifo_pop)
            begin
               next_s.out_valid = 1'b1;
               next_s.out_offset = s.out_offset + 8'h01;
               next_s.out_data = fifo_out.data;
               next_s.pay_cnt = s.pay_cnt + 7'h01;
               // the hundredth byte closes the frame even mid packet
               next_s.out_last = fifo_out.last |
                  (s.pay_cnt == `RXF_PAYLOAD_MAX - 7'h01);
               if (fifo_out.last)
               begin
                  next_s.state = rx_frame_pkg::S_IDLE;
                  next_s.frames = s.frames + 16'h0001;
               end
               else if (s.pay_cnt == `RXF_PAYLOAD_MAX - 7'h01)
               begin
                  next_s.state = rx_frame_pkg::S_DISCARD;
                  next_s.frames = s.frames + 16'h0001;
                  next_s.truncs = s.truncs + 8'h01;
               end
            end
         end
         rx_frame_pkg::S_DISCARD:
         begin
            // excess bytes are dropped up to the packet end
            if (fifo_pop & fifo_out.last)
            begin
               next_s.state = rx_frame_pkg::S_IDLE;
            end
         end
         // unused state codes fall back to idle
         default:
         begin
            next_s.state = rx_frame_pkg::S_IDLE;
         end
      endcase

      // ==========================================
      // register slave: one wait cycle, then the answer
      // map, byte addresses:
      //    control 0x00: bit 0 enable, bit 1 write one to clear counters
      //    status 0x04, read only: bit 0 busy, bits 15:8 cut frames,
      //    bits 31:16 frames sent
      // other addresses read zero and ignore writes; the answer is
      // registered, which costs a wait cycle but keeps the read data
      // path off the decode logic
      next_s.ack = (read_i | write_i) & ~s.ack;
      next_s.waitreq = ~next_s.ack;
      if ((read_i | write_i) & ~s.ack)
      begin
         next_s.rdata = 32'h0000_0000;
         if (read_i & (address_i == `RXF_REG_CTRL))
         begin
            next_s.rdata[`RXF_CTRL_ENABLE] = s.enable;
         end
         else if (read_i & (address_i == `RXF_REG_STATUS))
         begin
            next_s.rdata[`RXF_STAT_BUSY] = (s.state != rx_frame_pkg::S_IDLE);
            next_s.rdata[`RXF_STAT_TRUNC_LSB +: 8] = s.truncs;
            next_s.rdata[`RXF_STAT_FRAMES_LSB +: 16] = s.frames;
         end
      end
      // clearing the counters loses no event: the increment is kept
      if (s.ack & write_i & (address_i == `RXF_REG_CTRL) & byteenable_i[0])
      begin
         next_s.enable = writedata_i[`RXF_CTRL_ENABLE];
         if (writedata_i[`RXF_CTRL_CLEAR])
         begin
            next_s.frames = next_s.frames - s.frames;
            next_s.truncs = next_s.truncs - s.truncs;
         end
      end
      // a new descriptor is only taken between frames while enabled
      next_s.pkt_ready = (next_s.state == rx_frame_pkg::S_IDLE) &
         next_s.enable & ~(pkt_valid_i & s.pkt_ready);
   end

   // ==========================================
   // state register; reset leaves the block idle and enabled, with the
   // bus not answering
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s <= '0;
         s.state <= rx_frame_pkg::S_IDLE;
         s.enable <= `RXF_CTRL_RESET;
         s.waitreq <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

endmodule

// [testbench/rx_builder_chk.sv]
`timescale 1ns/1ps

// ==========================================
// port checks for the frame builder
module rx_builder_chk
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic pkt_valid_i,
   input wire rx_frame_pkg::pkt_desc_t pkt_desc_i,
   input wire logic pkt_ready_o,
   input wire logic out_valid_o,
   input wire logic [7:0] out_data_o,
   input wire logic out_last_o,
   input wire logic [7:0] out_offset_o,
   input wire logic out_ready_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic waitrequest_o
);
   rx_frame_pkg::pkt_desc_t d;
   logic [7:0] opt;
   logic [7:0] typ;

   // keep the descriptor the running frame was built from
   always_ff @(posedge core_clk_i or negedge nrst_i)
      if (!nrst_i)
         d <= '0;
      else if (pkt_valid_i && pkt_ready_o)
         d <= pkt_desc_i;

   // options offset and type code follow from the latched fields
   assign opt = d.addr64 ? 8'h0e : 8'h08;
   assign typ = {6'h20, d.is_io, !d.addr64};

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   a_type_code: assert property (
      out_valid_o && out_offset_o == 8'h04 |-> out_data_o == typ)
      else $error("wrong frame type");
   a_addr_msb: assert property (
      out_valid_o && out_offset_o == 8'h05 |-> out_data_o ==
      (d.addr64 ? d.src_addr[63:56] : d.src_addr[15:8]))
      else $error("address not msb first");
   a_strength_pos: assert property (
      out_valid_o && out_offset_o == opt - 8'h01 |->
      out_data_o == d.strength)
      else $error("strength byte misplaced");
   a_opt_bits: assert property (
      out_valid_o && out_offset_o == opt |-> out_data_o ==
      {5'h00, d.pan_bcast, d.addr_bcast, 1'b0})
      else $error("options byte wrong");
   a_chan_hi: assert property (
      out_valid_o && d.is_io && out_offset_o == opt + 8'h01 |->
      out_data_o == {3'h0, d.analog_channel_select_bits,
      d.digital_line_select_bits[8]})
      else $error("channel indicator wrong");
   a_pay_cap: assert property (
      out_valid_o && out_last_o |-> out_offset_o <= opt + 8'h64)
      else $error("payload over limit");
   a_byte_hold: assert property (
      out_valid_o && !out_ready_i |=> out_valid_o &&
      $stable(out_data_o) && $stable(out_offset_o))
      else $error("byte changed while stalled");
   a_offset_step: assert property (
      (out_valid_o && out_ready_i && !out_last_o) ##1 out_valid_o
      |-> out_offset_o == $past(out_offset_o) + 8'h01)
      else $error("offset skipped");
   a_take_busy: assert property (
      pkt_valid_i && pkt_ready_o |=> !pkt_ready_o [*4])
      else $error("second descriptor taken mid frame");
   a_bus_answer: assert property (
      (read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1
      waitrequest_o)
      else $error("bus answer not one cycle");
endmodule

bind rx_api_frame_builder rx_builder_chk i_chk
(
   .core_clk_i(core_clk_i),
   .nrst_i(nrst_i),
   .pkt_valid_i(pkt_valid_i),
   .pkt_desc_i(pkt_desc_i),
   .pkt_ready_o(pkt_ready_o),
   .out_valid_o(out_valid_o),
   .out_data_o(out_data_o),
   .out_last_o(out_last_o),
   .out_offset_o(out_offset_o),
   .out_ready_i(out_ready_i),
   .read_i(read_i),
   .write_i(write_i),
   .waitrequest_o(waitrequest_o)
);

// [testbench/host_sink.sv]
`timescale 1ns/1ps

// ==========================================
// host side: collects frame bytes, may stall
module host_sink
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic slow_i,
   input wire logic valid_i,
   input wire logic [7:0] data_i,
   input wire logic last_i,
   output logic ready_o
);
   logic [7:0] got[$];
   int frames = 0;
   logic tog;

   // slow mode takes every other cycle, like a busy uart
   always @(posedge core_clk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         ready_o <= 1'b0;
         tog <= 1'b0;
      end
      else
      begin
         tog <= !tog;
         ready_o <= !slow_i || tog;
         if (valid_i && ready_o)
         begin
            got.push_back(data_i); // raw frame bytes, no decode
            if (last_i)
               frames <= frames + 1;
         end
      end
endmodule

// [testbench/rx_api_frame_builder_tb.sv]
`timescale 1ns/1ps

module rx_api_frame_builder_tb;
   typedef struct {
      rx_frame_pkg::pkt_desc_t d;
      int n;
      logic [7:0] typ;
      int len;
   } row_t;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic pkt_valid = 1'b0;
   rx_frame_pkg::pkt_desc_t pkt_desc = '0;
   logic pay_valid = 1'b0;
   logic [7:0] pay_data = 8'h00;
   logic pay_last = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic slow = 1'b0;
   logic pkt_ready_o, pay_ready_o, out_valid_o, out_last_o, out_ready;
   logic waitrequest_o;
   logic [7:0] out_data_o;
   logic [31:0] readdata_o, r;
   row_t rows[6];
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   logic [3:0] rst_view;

   // what must stand while reset is held
   assign rst_view = {waitrequest_o, pkt_ready_o, out_valid_o, pay_ready_o};

   rx_api_frame_builder i_rx_api_frame_builder (.core_clk_i(core_clk),
      .nrst_i(nrst), .pkt_valid_i(pkt_valid), .pkt_desc_i(pkt_desc),
      .pkt_ready_o(pkt_ready_o), .pay_valid_i(pay_valid),
      .pay_data_i(pay_data), .pay_last_i(pay_last),
      .pay_ready_o(pay_ready_o), .out_valid_o(out_valid_o),
      .out_data_o(out_data_o), .out_last_o(out_last_o),
      .out_offset_o(), .out_ready_i(out_ready), .address_i(address),
      .read_i(read), .write_i(write), .writedata_i(wdata),
      .byteenable_i(4'hf), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o));
   host_sink i_host_sink (.core_clk_i(core_clk), .nrst_i(nrst),
      .slow_i(slow), .valid_i(out_valid_o), .data_i(out_data_o),
      .last_i(out_last_o), .ready_o(out_ready));

   // ==========================================
   // clock and hang guard
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         final_report();
      end
   end

   // ==========================================
   // helpers
   task final_report;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(logic [31:0] g, logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask

   function automatic logic [7:0] pay(int p);
      return 8'(p) ^ 8'ha5;
   endfunction

   // expected byte k of a frame, k = 0 being the type byte
   function automatic logic [7:0] exp_byte(rx_frame_pkg::pkt_desc_t d,
      int k);
      int na;
      na = d.addr64 ? 8 : 2;
      if (k <= na)
         return d.src_addr[8*(na-k) +: 8];
      if (k == na + 1)
         return d.strength;
      if (k == na + 2)
         return {5'h00, d.pan_bcast, d.addr_bcast, 1'b0};
      if (d.is_io && k == na + 3)
         return {3'h0, d.analog_channel_select_bits,
            d.digital_line_select_bits[8]};
      if (d.is_io && k == na + 4)
         return d.digital_line_select_bits[7:0];
      return pay(k - na - (d.is_io ? 5 : 3));
   endfunction

   // bus cycle; the leading edge keeps back-to-back requests apart
   task bus(logic wr, logic [7:0] a, logic [31:0] w);
      @(posedge core_clk);
      read <= !wr;
      write <= wr;
      address <= a;
      wdata <= w;
      do @(posedge core_clk); while (waitrequest_o !== 1'b0);
      r = readdata_o;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task push_pay(int n);
      for (int i = 0; i < n; i++)
      begin
         pay_valid <= 1'b1;
         pay_data <= pay(i);
         pay_last <= (i == n - 1);
         do @(posedge core_clk); while (pay_ready_o !== 1'b1);
      end
      pay_valid <= 1'b0;
   endtask

   // lag holds the descriptor back so the payload buffer fills first
   task run(row_t w, int lag);
      int f;
      f = i_host_sink.frames;
      i_host_sink.got.delete();
      fork
         push_pay(w.n);
         begin
            if (lag > 0)
            begin
               repeat (lag) @(posedge core_clk);
               #1 chk(pay_ready_o, 1'b0);
               @(posedge core_clk);
            end
            pkt_valid <= 1'b1;
            pkt_desc <= w.d;
            do @(posedge core_clk); while (pkt_ready_o !== 1'b1);
            pkt_valid <= 1'b0;
         end
      join
      while (i_host_sink.frames == f) @(posedge core_clk);
      // one idle edge, so the next run never drives a strobe twice at once
      @(posedge core_clk);
      chk(i_host_sink.got.size(), w.len);
      chk(i_host_sink.got[0], w.typ);
      for (int k = 1; k < w.len; k++)
         chk(i_host_sink.got[k], exp_byte(w.d, k));
   endtask

   // ==========================================
   // main sequence
   initial
   begin
      rows[0] = '{'{1'b0, 1'b0, 64'h9_0000_1234, 8'h28, 1'b1, 1'b0,
         4'h0, 9'h000}, 3, 8'h81, 8};
      rows[1] = '{'{1'b0, 1'b1, 64'h0102_0304_0506_0708, 8'h5a, 1'b0,
         1'b1, 4'h0, 9'h000}, 1, 8'h80, 12};
      rows[2] = '{'{1'b1, 1'b1, 64'h1122_3344_5566_7788, 8'h30, 1'b1,
         1'b1, 4'ha, 9'h155}, 4, 8'h82, 17};
      rows[3] = '{'{1'b1, 1'b0, 64'hbeef, 8'h64, 1'b0, 1'b0, 4'h5,
         9'h0aa}, 2, 8'h83, 9};
      rows[4] = '{'{1'b1, 1'b0, 64'h0a0b, 8'h11, 1'b0, 1'b1, 4'h3,
         9'h1ff}, 120, 8'h83, 105};
      rows[5] = '{'{1'b0, 1'b0, 64'h0c0d, 8'h22, 1'b1, 1'b1, 4'h0,
         9'h000}, 20, 8'h81, 25};
      repeat (6) @(posedge core_clk);
      chk(rst_view, 4'h9);
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk(pkt_ready_o, 1'b1);
      @(posedge core_clk);
      for (int i = 0; i < 4; i++)
      begin
         slow <= i[0];
         run(rows[i], 0);
      end
      // cut to 100 bytes after the options, channel indicator included, while the host stalls
      slow <= 1'b1;
      run(rows[4], 0);
      // buffer filled until it refuses, then drained
      run(rows[5], 15);
      bus(1'b0, 8'h04, 32'h0000_0000);
      chk(r, 32'h0006_0100);
      bus(1'b0, 8'h00, 32'h0000_0000);
      chk(r, 32'h0000_0001);
      bus(1'b0, 8'h10, 32'h0000_0000);
      chk(r, 32'h0000_0000);
      bus(1'b1, 8'h00, 32'h0000_0002);
      bus(1'b0, 8'h04, 32'h0000_0000);
      chk(r, 32'h0000_0000);
      #1 chk(pkt_ready_o, 1'b0);
      @(posedge core_clk);
      bus(1'b1, 8'h00, 32'h0000_0001);
      repeat (2) @(posedge core_clk);
      #1 chk(pkt_ready_o, 1'b1);
      // reset between runs: a disabled block comes back enabled and working
      bus(1'b1, 8'h00, 32'h0000_0000);
      #1 chk(pkt_ready_o, 1'b0);
      @(posedge core_clk);
      nrst <= 1'b0;
      @(posedge core_clk);
      #1 chk(rst_view, 4'h9);
      @(posedge core_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk(pkt_ready_o, 1'b1);
      @(posedge core_clk);
      run(rows[0], 0);
      final_report();
   end
endmodule
